/* File: rtl/gamma_dac_pkg.sv */
// Package: constants and types for the gamma DAC serial loader
package gamma_dac_pkg;

    // --------------------------------------------------------------
    // Frame layout
    // --------------------------------------------------------------
    localparam int FRAME_BITS   = 17;
    localparam int ADDR_BITS    = 5;
    localparam int LEVEL_BITS   = 10;
    localparam int NUM_LEVELS   = 19;
    localparam int COMMON_INDEX = 18;
    localparam int CNT_BITS     = 5;
    localparam logic [CNT_BITS-1:0] FRAME_BITS_C = 5'h11;

    // --------------------------------------------------------------
    // Memory read sequence
    // --------------------------------------------------------------
    localparam int MEM_ADDR_BITS = 6;
    localparam int MEM_WORD_BITS = 16;
    localparam int MEM_CMD_BITS  = 9;                // start, opcode, address
    localparam logic [2:0] MEM_READ_HDR = 3'h6;      // Start bit 1, opcode 10
    localparam logic [MEM_ADDR_BITS-1:0] MEM_LAST_ADDR  = 6'h12;
    localparam logic [MEM_ADDR_BITS-1:0] MEM_FIRST_ADDR = 6'h00;

    // --------------------------------------------------------------
    // Reset values and refresh pacing
    // --------------------------------------------------------------
    localparam logic [LEVEL_BITS-1:0] LEVEL_RESET = 10'h000;
    localparam int MCLK_HZ         = 40_000_000;
    localparam int INT_OSC_HZ      = 80_000;
    localparam int INT_OSC_HALF    = MCLK_HZ / (2 * INT_OSC_HZ);   // Cycles per half period
    localparam logic [8:0] INT_OSC_HALF_C = 9'(INT_OSC_HALF);
    localparam int POR_TIME_US     = 100;
    localparam int POR_CYCLES      = (POR_TIME_US * (MCLK_HZ / 1_000_000));

    // --------------------------------------------------------------
    // Types
    // --------------------------------------------------------------
    typedef struct packed {
        logic                  test_bit;
        logic                  osc_ext;
        logic [ADDR_BITS-1:0]  addr;
        logic [LEVEL_BITS-1:0] level;
    } frame_t;

    typedef enum logic [1:0] {
        AR_IDLE = 2'b00,
        AR_CMD  = 2'b01,
        AR_DATA = 2'b10,
        AR_GAP  = 2'b11
    } ar_state_t;

endpackage

/* File: rtl/sync_bit.sv */
// Two flip-flop synchroniser for a single level from outside the clock domain
module sync_bit (
    input  wire logic mclk_i,
    input  wire logic sys_rst_i,
    input  wire logic d_i,
    output logic      q_o
);
    // --------------------------------------------------------------
    // Synchroniser chain
    // --------------------------------------------------------------
    logic meta_ff;

    // First stage feeds only the second stage
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            meta_ff <= 1'b0;
            q_o     <= 1'b0;
        end else begin
            meta_ff <= d_i;
            q_o     <= meta_ff;
        end
    end
endmodule

/* File: rtl/gamma_dac_serial_loader.sv */
// Gamma DAC serial loader: three-wire frame receiver, memory auto-read, refresh pacing
// What this block does
// - Shift serial_in on serial clock rise, strobe low
// - Strobe rise writes frame to addressed register
// - Short frames are discarded, registers unchanged
// - Long frames keep only last 17 bits
// - Second bit selects internal or external refresh
// - Bits d2-d6 address, d7-d16 level, MSB first
// - Addresses 0-17 gamma, 18 common output
// - Reset clears every level register to zero
// - Supply-up reset initialises receiver, sequencer, registers
// - Memory pins change and sample on falling edges
// - Send start, read opcode, address; capture word
// - Memory word loads like a host frame
// - Read addresses 00H to 12H, then wrap
// - Repeat reads while autoload_disable is low
// - autoload_disable high stops reads, releases pins
// - Word D15 is d1, D14-D10 address, D9-D0 level
// - Refresh sample-and-hold paced by selected oscillator
// - Thermal shutdown disables all outputs until cooled
// - autoload_disable low enables, high disables auto-read
module gamma_dac_serial_loader
    import gamma_dac_pkg::*;
(
    input  wire logic                                  mclk_i,
    input  wire logic                                  sys_rst_i,
    input  wire logic                                  serial_clk_i,
    input  wire logic                                  serial_in_i,
    input  wire logic                                  load_strobe_i,
    input  wire logic                                  autoload_disable_i,
    input  wire logic                                  mem_data_in_i,
    input  wire logic                                  refresh_osc_pin_i,
    input  wire logic                                  thermal_shutdown_i,
    output logic                                       mem_select_o,
    output logic                                       mem_select_oe_o,
    output logic                                       mem_cmd_out_o,
    output logic                                       mem_cmd_out_oe_o,
    output logic [gamma_dac_pkg::NUM_LEVELS-1:0][gamma_dac_pkg::LEVEL_BITS-1:0] level_o,
    output logic                                       outputs_enable_o,
    output logic                                       osc_ext_o,
    output logic                                       refresh_tick_o,
    output logic [gamma_dac_pkg::CNT_BITS-1:0]         refresh_ch_o
);
    import gamma_dac_pkg::*;

    // --------------------------------------------------------------
    // Input synchronisers
    // --------------------------------------------------------------
    logic sclk_s;                  // Serial clock
    logic ser_in_s;                // Host data bit
    logic strobe_s;                // Load strobe
    logic ardis_s;                 // Auto-read disable level
    logic mdi_s;                   // Memory data bit
    logic oscp_s;                  // External refresh clock
    logic hot_s;                   // Over-temperature level
    logic sclk_d_ff;
    logic strobe_d_ff;
    logic oscp_d_ff;

    // Every pin has its own two-flop chain; all chains share one latency,
    // so data and clock keep their relative order after synchronisation
    sync_bit u_sync_sclk (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (serial_clk_i),
        .q_o       (sclk_s)
    );
    sync_bit u_sync_sin (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (serial_in_i),
        .q_o       (ser_in_s)
    );
    sync_bit u_sync_stb (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (load_strobe_i),
        .q_o       (strobe_s)
    );
    sync_bit u_sync_ard (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (autoload_disable_i),
        .q_o       (ardis_s)
    );
    sync_bit u_sync_mdi (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (mem_data_in_i),
        .q_o       (mdi_s)
    );
    sync_bit u_sync_osc (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (refresh_osc_pin_i),
        .q_o       (oscp_s)
    );
    sync_bit u_sync_hot (
        .mclk_i    (mclk_i),
        .sys_rst_i (sys_rst_i),
        .d_i       (thermal_shutdown_i),
        .q_o       (hot_s)
    );

    // Edge detectors look at synchronised copies only
    // A strobe held high through reset shows one false rise after release;
    // it only clears the already empty bit counter, so no load follows
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            sclk_d_ff   <= 1'b0;
            strobe_d_ff <= 1'b0;
            oscp_d_ff   <= 1'b0;
        end else begin
            sclk_d_ff   <= sclk_s;
            strobe_d_ff <= strobe_s;
            oscp_d_ff   <= oscp_s;
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic strobe_rise;
    logic oscp_rise;
    assign sclk_rise   = sclk_s & ~sclk_d_ff;
    assign sclk_fall   = ~sclk_s & sclk_d_ff;
    assign strobe_rise = strobe_s & ~strobe_d_ff;
    assign oscp_rise   = oscp_s & ~oscp_d_ff;

    // --------------------------------------------------------------
    // Host frame receiver
    // --------------------------------------------------------------
    logic [FRAME_BITS-1:0] host_sr_ff;
    logic [CNT_BITS-1:0]   host_cnt_ff;
    logic                  host_load;

    // Count saturates at 17 so an over-long frame still counts as complete
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            host_sr_ff  <= '0;
            host_cnt_ff <= '0;
        end else if (strobe_rise) begin
            host_cnt_ff <= '0;
        end else if (!strobe_s && sclk_rise) begin
            host_sr_ff <= {host_sr_ff[FRAME_BITS-2:0], ser_in_s};
            if (host_cnt_ff != FRAME_BITS_C) begin
                host_cnt_ff <= host_cnt_ff + 5'h01;
            end
        end
    end

    // Only a full frame may reach the register bank
    assign host_load = strobe_rise && (host_cnt_ff == FRAME_BITS_C);

    // --------------------------------------------------------------
    // Auto-read sequencer
    // --------------------------------------------------------------
    ar_state_t                 ar_state_ff;
    logic [MEM_CMD_BITS-1:0]   cmd_sr_ff;
    logic [MEM_WORD_BITS-1:0]  word_sr_ff;
    logic [CNT_BITS-1:0]       bit_cnt_ff;
    logic [MEM_ADDR_BITS-1:0]  mem_addr_ff;
    logic                      mem_load_ff;
    logic                      ar_enable;

    // The disable input is a plain level; reads restart from the first word
    // every time it goes low again, so a partial pass is never resumed
    assign ar_enable = ~ardis_s;

    // Pin updates and samples happen on a serial clock fall, except the clear of both pins while disabled
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ar_state_ff   <= AR_IDLE;
            cmd_sr_ff     <= '0;
            word_sr_ff    <= '0;
            bit_cnt_ff    <= '0;
            mem_addr_ff   <= MEM_FIRST_ADDR;
            mem_load_ff   <= 1'b0;
            mem_select_o  <= 1'b0;
            mem_cmd_out_o <= 1'b0;
        end else begin
            mem_load_ff <= 1'b0;
            if (!ar_enable) begin
                ar_state_ff   <= AR_IDLE;
                mem_addr_ff   <= MEM_FIRST_ADDR;
                mem_select_o  <= 1'b0;
                mem_cmd_out_o <= 1'b0;
            end else if (sclk_fall) begin
                case (ar_state_ff)
                    AR_IDLE: begin
                        // Select and first command bit go out together
                        mem_select_o  <= 1'b1;
                        mem_cmd_out_o <= MEM_READ_HDR[2];
                        cmd_sr_ff     <= {MEM_READ_HDR[1:0], mem_addr_ff, 1'b0};
                        bit_cnt_ff    <= 5'h01;
                        ar_state_ff   <= AR_CMD;
                    end
                    AR_CMD: begin
                        if (bit_cnt_ff == 5'(MEM_CMD_BITS)) begin
                            mem_cmd_out_o <= 1'b0;
                            bit_cnt_ff    <= '0;
                            ar_state_ff   <= AR_DATA;
                        end else begin
                            mem_cmd_out_o <= cmd_sr_ff[MEM_CMD_BITS-1];
                            cmd_sr_ff     <= {cmd_sr_ff[MEM_CMD_BITS-2:0], 1'b0};
                            bit_cnt_ff    <= bit_cnt_ff + 5'h01;
                        end
                    end
                    AR_DATA: begin
                        word_sr_ff <= {word_sr_ff[MEM_WORD_BITS-2:0], mdi_s};
                        bit_cnt_ff <= bit_cnt_ff + 5'h01;
                        if (bit_cnt_ff == 5'(MEM_WORD_BITS - 1)) begin
                            mem_select_o <= 1'b0;
                            mem_load_ff  <= 1'b1;
                            ar_state_ff  <= AR_GAP;
                        end
                    end
                    AR_GAP: begin
                        // Two deselected clocks between words (this state, then idle); the address steps here
                        mem_addr_ff <= (mem_addr_ff == MEM_LAST_ADDR) ?
                                       MEM_FIRST_ADDR : mem_addr_ff + 6'h01;
                        ar_state_ff <= AR_IDLE;
                    end
                    default: ar_state_ff <= AR_IDLE;
                endcase
            end
        end
    end

    // Pins float while another master owns the memory
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            mem_select_oe_o  <= 1'b0;
            mem_cmd_out_oe_o <= 1'b0;
        end else begin
            mem_select_oe_o  <= ar_enable;
            mem_cmd_out_oe_o <= ar_enable;
        end
    end

    // --------------------------------------------------------------
    // Frame selection: memory word mapped into frame positions
    // --------------------------------------------------------------
    frame_t frame;
    logic   do_load;

    // Test bit forced to zero for memory words; D15 lands on d1
    always_comb begin
        if (mem_load_ff) begin
            frame = frame_t'({1'b0, word_sr_ff});
        end else begin
            frame = frame_t'(host_sr_ff);
        end
    end
    // A host load in the same cycle as a memory word is lost; the memory
    // word wins because the same word comes round again on the next pass
    assign do_load = mem_load_ff | host_load;

    // --------------------------------------------------------------
    // Level register bank
    // --------------------------------------------------------------
    logic [NUM_LEVELS-1:0][LEVEL_BITS-1:0] level_ff;

    // Test bit is ignored; host keeps it zero. Unused addresses write nothing.
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            for (int i = 0; i < NUM_LEVELS; i++) begin
                level_ff[i] <= LEVEL_RESET;
            end
        end else if (do_load && (frame.addr <= 5'(COMMON_INDEX))) begin
            level_ff[frame.addr] <= frame.level;
        end
    end

    // Oscillator mode bit travels with every accepted frame
    // Frames to unused addresses still carry a mode bit, so they update it
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            osc_ext_o <= 1'b0;
        end else if (do_load) begin
            osc_ext_o <= frame.osc_ext;
        end
    end

    // --------------------------------------------------------------
    // Thermal gating of outputs
    // --------------------------------------------------------------
    // Levels are kept so outputs come back unchanged after cooling
    // Outputs lag the pin by the two sync flops plus this register
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            level_o          <= '0;
            outputs_enable_o <= 1'b0;
        end else begin
            outputs_enable_o <= ~hot_s;
            level_o          <= hot_s ? '0 : level_ff;
        end
    end

    // --------------------------------------------------------------
    // Refresh pacing
    // --------------------------------------------------------------
    logic [8:0] osc_div_ff;
    logic       int_osc_ff;
    logic       int_rise;

    // Internal oscillator approximated by a divider of the system clock
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            osc_div_ff <= '0;
            int_osc_ff <= 1'b0;
        end else if (osc_div_ff == INT_OSC_HALF_C - 9'h001) begin
            osc_div_ff <= '0;
            int_osc_ff <= ~int_osc_ff;
        end else begin
            osc_div_ff <= osc_div_ff + 9'h001;
        end
    end
    // The divider only approximates the nominal oscillator; a system clock
    // other than the package figure shifts the refresh rate with it
    assign int_rise = (osc_div_ff == INT_OSC_HALF_C - 9'h001) && !int_osc_ff;

    // One channel refreshed per oscillator period, round robin
    // The channel count runs apart from the levels; the amplifier side
    // reads the stored level of whichever channel this one names
    always_ff @(posedge mclk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            refresh_tick_o <= 1'b0;
            refresh_ch_o   <= '0;
        end else begin
            refresh_tick_o <= osc_ext_o ? oscp_rise : int_rise;
            if (refresh_tick_o) begin
                refresh_ch_o <= (refresh_ch_o == 5'(COMMON_INDEX)) ? '0 : refresh_ch_o + 5'h01;
            end
        end
    end
endmodule

/* File: sim/gamma_dac_chk.sv */
// Checker: port-level relations of the gamma DAC serial loader
module gamma_dac_chk
    import gamma_dac_pkg::*;
(
    input  wire logic                                  mclk_i,
    input  wire logic                                  sys_rst_i,
    input  wire logic                                  load_strobe_i,
    input  wire logic                                  autoload_disable_i,
    input  wire logic                                  thermal_shutdown_i,
    input  wire logic                                  mem_select_o,
    input  wire logic                                  mem_select_oe_o,
    input  wire logic                                  mem_cmd_out_o,
    input  wire logic                                  mem_cmd_out_oe_o,
    input  wire logic [NUM_LEVELS-1:0][LEVEL_BITS-1:0] level_o,
    input  wire logic                                  outputs_enable_o,
    input  wire logic                                  refresh_tick_o,
    input  wire logic [CNT_BITS-1:0]                   refresh_ch_o
);
    // --------------------------------------------------------------
    // Assertions, all in the system clock domain
    // --------------------------------------------------------------
    default clocking dcb @(posedge mclk_i); endclocking
    default disable iff (sys_rst_i);

    // Six cycles cover the two-flop sync plus the output register
    a_hot_zero: assert property (thermal_shutdown_i[*6] |-> !outputs_enable_o && level_o == '0)
        else $error("outputs still on while hot");
    a_cool_on: assert property (!thermal_shutdown_i[*6] |-> outputs_enable_o)
        else $error("outputs not restored after cooling");
    a_pins_off: assert property (autoload_disable_i[*6] |-> !mem_select_oe_o && !mem_cmd_out_oe_o)
        else $error("memory pins driven while auto-read is off");
    a_pins_on: assert property (!autoload_disable_i[*6] |-> mem_select_oe_o && mem_cmd_out_oe_o)
        else $error("memory pins released while auto-read is on");
    a_sel_idle: assert property (!mem_select_oe_o |-> !mem_select_o)
        else $error("select active while released");
    a_cmd_idle: assert property (!mem_cmd_out_oe_o |-> !mem_cmd_out_o)
        else $error("command bit active while released");
    a_tick_pulse: assert property (refresh_tick_o |=> !refresh_tick_o)
        else $error("refresh tick longer than one cycle");
    a_ch_range: assert property (refresh_ch_o <= 5'h12)
        else $error("refresh channel out of range");
    // Only a strobe rise, a memory word or thermal gating may change the levels
    a_level_hold: assert property ((autoload_disable_i && !thermal_shutdown_i && $stable(load_strobe_i))[*8]
        |-> $stable(level_o))
        else $error("level changed without a load");
endmodule

bind gamma_dac_serial_loader gamma_dac_chk i_chk (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .load_strobe_i(load_strobe_i),
    .autoload_disable_i(autoload_disable_i), .thermal_shutdown_i(thermal_shutdown_i),
    .mem_select_o(mem_select_o), .mem_select_oe_o(mem_select_oe_o), .mem_cmd_out_o(mem_cmd_out_o),
    .mem_cmd_out_oe_o(mem_cmd_out_oe_o), .level_o(level_o), .outputs_enable_o(outputs_enable_o),
    .refresh_tick_o(refresh_tick_o), .refresh_ch_o(refresh_ch_o)
);

/* File: sim/serial_mem_model.sv */
// Serial memory model answering the read commands of the auto-read sequencer
module serial_mem_model (
    input  wire logic sclk_i,
    input  wire logic sel_i,
    input  wire logic cmd_i,
    output logic      dout_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int          cnt = 0;
    logic [5:0]  addr = '0;
    logic [2:0]  hdr = '0;
    logic [15:0] w;

    // Data moves on serial clock rises so it is settled at the falls that sample it
    always @(posedge sclk_i) begin
        w = {1'b1, addr[4:0], {addr[4:0], addr[4:0]} ^ 10'h2a5};
        cnt = sel_i ? cnt + 1 : 0;
        if (cnt >= 1 && cnt <= 3) hdr = {hdr[1:0], cmd_i};
        if (cnt >= 4 && cnt <= 9) addr = {addr[4:0], cmd_i};
        // A bad header or an idle line gives a toggling level, never a held value
        if (cnt >= 10 && cnt <= 25 && hdr == 3'h6) dout_o = w[25-cnt];
        else dout_o = (dout_o === 1'b1) ? 1'b0 : 1'b1;
    end
endmodule

/* File: sim/test_gamma_dac_serial_loader.sv */
// Testbench for the gamma DAC serial loader
module test_gamma_dac_serial_loader;
    timeunit 1ns;
    timeprecision 100ps;
    import gamma_dac_pkg::*;
    logic mclk_i = 0, sys_rst_i = 1, sclk = 0, sin = 0, strobe = 1, ard = 1, hot = 0, opin = 0;
    logic sel, sel_oe, cmd, cmd_oe, oen, osc, tick, mdin;
    logic [NUM_LEVELS-1:0][LEVEL_BITS-1:0] lvl;
    logic [CNT_BITS-1:0]   ch;
    logic [LEVEL_BITS-1:0] exp_lvl [NUM_LEVELS];
    int mismatches = 0, n_checks = 0, ticks = 0, ocnt = 0;
    // Board pulls: select down, command line up
    wire sel_w = sel_oe ? sel : 1'b0;
    wire cmd_w = cmd_oe ? cmd : 1'b1;

    initial forever #12.5 mclk_i = ~mclk_i;

    // External refresh clock with a rise every 100 cycles; ticks counted
    always @(posedge mclk_i) begin
        ocnt <= (ocnt == 49) ? 0 : ocnt + 1;
        if (ocnt == 49) opin <= ~opin;
        if (tick === 1'b1) ticks <= ticks + 1;
    end

    gamma_dac_serial_loader i_dut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .serial_clk_i(sclk), .serial_in_i(sin),
        .load_strobe_i(strobe), .autoload_disable_i(ard), .mem_data_in_i(mdin),
        .refresh_osc_pin_i(opin), .thermal_shutdown_i(hot), .mem_select_o(sel),
        .mem_select_oe_o(sel_oe), .mem_cmd_out_o(cmd), .mem_cmd_out_oe_o(cmd_oe), .level_o(lvl),
        .outputs_enable_o(oen), .osc_ext_o(osc), .refresh_tick_o(tick), .refresh_ch_o(ch)
    );
    serial_mem_model i_mem (.sclk_i(sclk), .sel_i(sel_w), .cmd_i(cmd_w), .dout_o(mdin));

    // --------------------------------------------------------------
    // Shared tasks
    // --------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        n_checks++;
        if (seen !== want) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic summarize();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    // One serial clock period is 8 cycles, so high and low each last 100 ns
    task automatic pulse();
        cyc(4);
        sclk <= 1;
        cyc(4);
        sclk <= 0;
    endtask
    // Bits go MSB first while the strobe is low; the strobe rise loads
    task automatic send(input logic [31:0] v, input int n);
        strobe <= 0;
        for (int i = n - 1; i >= 0; i--) begin
            sin <= v[i];
            pulse();
        end
        cyc(4);
        strobe <= 1;
        cyc(8);
    endtask
    function automatic logic [31:0] frm(input logic o, input logic [4:0] a, input logic [9:0] l);
        return {15'h0, 1'b0, o, a, l};
    endfunction
    task automatic cmp_all(input string name);
        for (int k = 0; k < NUM_LEVELS; k++) chk(32'(lvl[k]), 32'(exp_lvl[k]));
        $display("test %s done", name);
    endtask

    initial begin
        cyc(100000);
        mismatches++;
        summarize();
    end

    // --------------------------------------------------------------
    // Main sequence
    // --------------------------------------------------------------
    initial begin
        logic [4:0]  a;
        logic [9:0]  l;
        logic [15:0] w;
        int          t0;
        int          c0;
        void'($urandom(69088));
        foreach (exp_lvl[k]) exp_lvl[k] = LEVEL_RESET;
        cyc(3);
        sys_rst_i <= 0;
        cyc(6);
        chk(32'(oen), 1);
        chk(32'(osc), 0);
        cmp_all("reset");
        // Internal oscillator gives one tick per 500 cycles
        t0 = ticks;
        c0 = ch;
        cyc(2000);
        chk(32'(ticks - t0 >= 3 && ticks - t0 <= 5), 1);
        chk(32'(ch), 32'((c0 + ticks - t0) % NUM_LEVELS));
        // Address and level corners first, then random frames
        for (int i = 0; i < 14; i++) begin
            a = (i == 0) ? 5'h00 : (i == 1) ? 5'h12 : 5'($urandom_range(18, 0));
            l = (i < 2) ? 10'h3ff : 10'($urandom);
            send(frm(i[0], a, l), FRAME_BITS);
            exp_lvl[a] = l;
            chk(32'(osc), 32'(i[0]));
        end
        cmp_all("host frames");
        // External pin now paces refresh, one tick per pin rise
        t0 = ticks;
        c0 = ch;
        cyc(1000);
        chk(32'(ticks - t0 >= 9 && ticks - t0 <= 11), 1);
        chk(32'(ch), 32'((c0 + ticks - t0) % NUM_LEVELS));
        send(frm(1'b0, 5'h07, 10'h155), 16);
        cmp_all("short frame");
        send(frm(1'b0, 5'($urandom_range(31, 19)), 10'h2aa), FRAME_BITS);
        cmp_all("bad address");
        send(frm(1'b0, 5'h09, 10'h0f3) | 32'h000e0000, 20);
        exp_lvl[9] = 10'h0f3;
        cmp_all("long frame");
        hot <= 1;
        cyc(8);
        chk(32'(oen), 0);
        chk(32'(|lvl), 0);
        hot <= 0;
        cyc(8);
        chk(32'(oen), 1);
        cmp_all("thermal");
        // Auto-read with a free-running serial clock long enough for every word
        ard <= 0;
        pulse();
        chk(32'({sel_oe, cmd_oe}), 32'h3);
        repeat (620) pulse();
        ard <= 1;
        cyc(8);
        chk(32'({sel_oe, cmd_oe}), 0);
        for (int k = 0; k < NUM_LEVELS; k++) begin
            w = {1'b1, 5'(k), {5'(k), 5'(k)} ^ 10'h2a5};
            exp_lvl[k] = w[9:0];
        end
        chk(32'(osc), 1);
        cmp_all("auto-read");
        summarize();
    end
endmodule
